// File: eid_detect.sv
// eid_detect: per-line sense detection over synchronised samples.
// assumes inputs come from eid_sync; gives a set per line: a one-cycle pulse on edges, held while the line is low in low mode.
`timescale 1ns/1ns
module eid_detect #(
	parameter int LINES = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// synchronised levels and sense selection, two bits per line
	input wire logic [LINES-1:0] level,
	input wire logic [2*LINES-1:0] sense,
	// detection results
	output logic [LINES-1:0] hit
);
	// previous sample of every line
	typedef struct packed {
		logic [LINES-1:0] prev;
	} eid_detect_s;
	eid_detect_s st;
	eid_detect_s next_st;

	// keep the last sample for edge comparison
	always_comb begin
		next_st.prev = level;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	// one detector per line
	for (genvar i = 0; i < LINES; i++) begin : g_line
		logic fall;
		logic rise;
		assign fall = st.prev[i] & ~level[i];
		assign rise = ~st.prev[i] & level[i];
		always_comb begin
			case (eid_pkg::eid_sense_e'(sense[2*i+:2]))
				eid_pkg::EID_SENSE_LOW: hit[i] = ~level[i];
				eid_pkg::EID_SENSE_FALL: hit[i] = fall;
				eid_pkg::EID_SENSE_RISE: hit[i] = rise;
				default: hit[i] = fall | rise;
			endcase
		end
	end
endmodule

// File: eid_pins_model.sv
// eid_pins_model: far-side devices on the request and nmi pins.
// assumes the bench calls drive just after reset and between bus cycles.
`timescale 1ns/1ns
module eid_pins_model (
	// clock for timing only
	input wire logic mclk,
	// pins, idle high
	output logic [15:0] irq_pin_n,
	output logic [15:0] alt_request_pin_n,
	output logic nmi_pin
);
	// only this model drives the pins, so no other function fights them
	initial begin
		irq_pin_n = 16'hFFFF;
		alt_request_pin_n = 16'hFFFF;
		nmi_pin = 1'b1;
	end
	// change levels after an edge, then hold them
	task automatic drive(input logic [15:0] p, input logic [15:0] a, input logic n, input int hold);
		@(posedge mclk);
		irq_pin_n <= p;
		alt_request_pin_n <= a;
		nmi_pin <= n;
		repeat (hold) @(posedge mclk);
	endtask
endmodule

// File: eid_pkg.sv
// eid_pkg: register map, field layout, reset values and sense encodings
// for the external request detect, flag and enable block.
// assumes a 32-bit classic wishbone slave; each register is one aligned word.
package eid_pkg;
	// number of external request lines
	localparam int NUM_LINES = 16;
	// register byte offsets
	localparam logic [7:0] OFS_ENABLE_LOW = 8'h00;
	localparam logic [7:0] OFS_ENABLE_HIGH = 8'h04;
	localparam logic [7:0] OFS_FLAG_LOW = 8'h08;
	localparam logic [7:0] OFS_FLAG_HIGH = 8'h0C;
	localparam logic [7:0] OFS_SENSE = 8'h10;
	localparam logic [7:0] OFS_SOURCE = 8'h14;
	localparam logic [7:0] OFS_SYSCTL = 8'h18;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h1C;
	localparam logic [7:0] OFS_EVT_MASK = 8'h20;
	localparam logic [7:0] OFS_VECTOR = 8'h24;
	// system control field positions
	localparam int SYSCTL_NMI_EDGE_POS = 0;
	// event status field positions
	localparam int EVT_NMI_POS = 0;
	localparam int EVT_WAKE_POS = 1;
	localparam int EVT_WIDTH = 2;
	// reset values
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [31:0] SENSE_RESET = 32'h0000_0000;
	localparam logic [15:0] SOURCE_RESET = 16'h0000;
	// first vector number of lines 0..7 and of lines 8..15
	localparam logic [7:0] VEC_BASE_LOW = 8'h10;
	localparam logic [7:0] VEC_BASE_HIGH = 8'h38;
	localparam logic [7:0] VEC_NMI = 8'h07;
	// sense selection encodings
	typedef enum logic [1:0] {
		EID_SENSE_LOW = 2'b00,
		EID_SENSE_FALL = 2'b01,
		EID_SENSE_RISE = 2'b10,
		EID_SENSE_BOTH = 2'b11
	} eid_sense_e;
endpackage

// File: eid_sync.sv
// eid_sync: two-flop synchroniser for a group of asynchronous pins.
// assumes the pins change without regard to mclk.
`timescale 1ns/1ns
module eid_sync #(
	parameter int WIDTH = 17
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// raw and synchronised levels
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] reset_level,
	output logic [WIDTH-1:0] pin_sync
);
	// state of the two stages
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} eid_sync_s;
	eid_sync_s st;
	eid_sync_s next_st;

	// first stage only feeds the second
	always_comb begin
		next_st.meta = pin_in;
		next_st.sync = st.meta;
	end

	// registers; reset to all ones so idle-high pins show no edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync = st.sync;
endmodule

// File: eid_top.sv
// eid_top: external request detect, flag and enable block with a wishbone
// register slave, nmi edge detection and an event interrupt output.
// assumes a classic wishbone master on mclk and an async-low rstn.
// Contract
// - sixteen enable bits, cleared at reset, gate requests
// - detection sets the line status flag
// - software clears flag only by read one, write zero
// - low level: handling clears flag when input high
// - edge modes: handling clears flag automatically
// - nmi always requested, never masked
// - config bit picks nmi rising or falling
// - each line has its own vector
// - four sense choices per line
// - line driven by primary or alternate pin
// - detection ignores port direction
// - nmi and lines wake from standby
// - sense codes 00 low,01 fall,10 rise,11 both
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module eid_top #(
	parameter int LINES = eid_pkg::NUM_LINES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// request pins, active low, sampled whatever the port direction
	input wire logic [15:0] irq_pin_n,
	input wire logic [15:0] alt_request_pin_n,
	input wire logic nmi_pin,
	// cpu side: exception handling acknowledge for one line
	input wire logic line_ack,
	input wire logic [3:0] line_ack_num,
	input wire logic standby,
	// cpu side requests
	output logic [15:0] line_req,
	output logic [7:0] req_vector,
	output logic req_valid,
	output logic nmi_req,
	output logic wake,
	// event interrupt output
	output logic irq
);
	// whole register state of the block
	typedef struct packed {
		logic [7:0] int_enable_low;
		logic [7:0] int_enable_high;
		logic [7:0] int_flag_low;
		logic [7:0] int_flag_high;
		logic [31:0] sense_select_reg;
		logic [15:0] src_alt;
		logic [7:0] system_control_reg;
		// flags seen as one by a read, armed for clearing
		logic [15:0] read_one;
		logic nmi_prev;
		logic nmi_pulse;
		logic wake;
		logic [eid_pkg::EVT_WIDTH-1:0] evt_status;
		logic [eid_pkg::EVT_WIDTH-1:0] evt_mask;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} eid_top_s;
	eid_top_s st;
	eid_top_s next_st;

	// synchronised pins; bit 16 carries nmi
	logic [16:0] raw_pins;
	logic [16:0] sync_pins;
	// per-line levels and detector results after the synchroniser
	logic [15:0] line_level;
	logic [15:0] hit;
	// sixteen-bit views of the byte registers
	logic [15:0] flags;
	logic [15:0] enables;
	// nmi level and its selected edge
	logic nmi_level;
	logic nmi_edge;
	// bus request and write lane handling
	logic bus_req;
	logic [31:0] wmask;
	logic [31:0] wval;
	// flag clears from handling and from software
	logic [15:0] hw_clear;
	logic [15:0] sw_clear;
	logic [15:0] next_flags;
	// lowest pending line and whether any line is pending
	logic [3:0] best;
	logic any_req;

	// choose the source pin for every line
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			// alternate pin when its select bit is set
			raw_pins[i] = st.src_alt[i] ? alt_request_pin_n[i] : irq_pin_n[i];
		end
		// nmi has a single pin
		raw_pins[16] = nmi_pin;
	end

	// pin synchroniser
	eid_sync #(
		.WIDTH(17)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pin_in(raw_pins),
		.reset_level({17{1'b1}}),
		.pin_sync(sync_pins)
	);
	// split the synchronised word into lines and nmi
	assign line_level = sync_pins[15:0];
	assign nmi_level = sync_pins[16];

	// per-line sense detectors
	eid_detect #(
		.LINES(16)
	) u_detect (
		.mclk(mclk),
		.rstn(rstn),
		.level(line_level),
		.sense(st.sense_select_reg),
		.hit(hit)
	);

	assign flags = {st.int_flag_high, st.int_flag_low};
	assign enables = {st.int_enable_high, st.int_enable_low};
	// nmi edge per selected polarity; 1 picks rising
	assign nmi_edge = st.system_control_reg[eid_pkg::SYSCTL_NMI_EDGE_POS] ?
		(~st.nmi_prev & nmi_level) : (st.nmi_prev & ~nmi_level);

	// byte-lane write mask and single-cycle request
	assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack & ~st.err;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b+:8] = {8{wb_sel_i[b]}};
		end
		wval = wb_dat_i;
	end

	// lowest-numbered pending line is presented first
	always_comb begin
		best = 4'h0;
		any_req = 1'b0;
		// scan downward so the lowest line wins
		for (int i = 15; i >= 0; i--) begin
			if (flags[i] & enables[i]) begin
				best = 4'(i);
				any_req = 1'b1;
			end
		end
	end

	// next-state logic: flags, registers and bus answer
	always_comb begin
		next_st = st;
		// ack and err are one-cycle pulses
		next_st.ack = 1'b0;
		next_st.err = 1'b0;
		// nmi history and registered nmi pulse
		next_st.nmi_prev = nmi_level;
		next_st.nmi_pulse = nmi_edge;
		hw_clear = '0;
		sw_clear = '0;
		// exception handling clears its own flag
		if (line_ack) begin
			// low-level mode clears only while the pin is high
			if (st.sense_select_reg[2*line_ack_num+:2] == 2'(eid_pkg::EID_SENSE_LOW)) begin
				hw_clear[line_ack_num] = line_level[line_ack_num];
			end else begin
				hw_clear[line_ack_num] = 1'b1;
			end
		end
		// bus access
		if (bus_req) begin
			if (wb_adr_i == eid_pkg::OFS_ENABLE_LOW) begin
				// enable bits of lines 0..7
				next_st.ack = 1'b1;
				next_st.rdata = {24'h000000, st.int_enable_low};
				if (wb_we_i && wb_sel_i[0]) next_st.int_enable_low = wval[7:0];
			end else if (wb_adr_i == eid_pkg::OFS_ENABLE_HIGH) begin
				// enable bits of lines 8..15
				next_st.ack = 1'b1;
				next_st.rdata = {24'h000000, st.int_enable_high};
				if (wb_we_i && wb_sel_i[0]) next_st.int_enable_high = wval[7:0];
			end else if (wb_adr_i == eid_pkg::OFS_FLAG_LOW || wb_adr_i == eid_pkg::OFS_FLAG_HIGH) begin
				// status flags; a read arms, a zero write clears
				next_st.ack = 1'b1;
				if (wb_adr_i == eid_pkg::OFS_FLAG_LOW) begin
					next_st.rdata = {24'h000000, st.int_flag_low};
					if (!wb_we_i) next_st.read_one[7:0] = st.read_one[7:0] | st.int_flag_low;
					else if (wb_sel_i[0]) sw_clear[7:0] = st.read_one[7:0] & ~wval[7:0];
				end else begin
					next_st.rdata = {24'h000000, st.int_flag_high};
					if (!wb_we_i) next_st.read_one[15:8] = st.read_one[15:8] | st.int_flag_high;
					else if (wb_sel_i[0]) sw_clear[15:8] = st.read_one[15:8] & ~wval[7:0];
				end
				// a write consumes the read-one arming of the bytes it covers
				if (wb_we_i && wb_sel_i[0]) begin
					if (wb_adr_i == eid_pkg::OFS_FLAG_LOW) next_st.read_one[7:0] = 8'h00;
					else next_st.read_one[15:8] = 8'h00;
				end
			end else if (wb_adr_i == eid_pkg::OFS_SENSE) begin
				// two sense bits per line, written per lane
				next_st.ack = 1'b1;
				next_st.rdata = st.sense_select_reg;
				if (wb_we_i) next_st.sense_select_reg = (st.sense_select_reg & ~wmask) | (wval & wmask);
			end else if (wb_adr_i == eid_pkg::OFS_SOURCE) begin
				// one alternate-pin select bit per line
				next_st.ack = 1'b1;
				next_st.rdata = {16'h0000, st.src_alt};
				if (wb_we_i) next_st.src_alt = (st.src_alt & ~wmask[15:0]) | (wval[15:0] & wmask[15:0]);
			end else if (wb_adr_i == eid_pkg::OFS_SYSCTL) begin
				// system control; bit 0 picks the nmi edge
				next_st.ack = 1'b1;
				next_st.rdata = {24'h000000, st.system_control_reg};
				if (wb_we_i && wb_sel_i[0]) next_st.system_control_reg = wval[7:0];
			end else if (wb_adr_i == eid_pkg::OFS_EVT_STATUS) begin
				// sticky events; a one written clears
				next_st.ack = 1'b1;
				next_st.rdata = {30'h00000000, st.evt_status};
				if (wb_we_i && wb_sel_i[0]) next_st.evt_status = st.evt_status & ~wval[eid_pkg::EVT_WIDTH-1:0];
			end else if (wb_adr_i == eid_pkg::OFS_EVT_MASK) begin
				// event mask for the irq output
				next_st.ack = 1'b1;
				next_st.rdata = {30'h00000000, st.evt_mask};
				if (wb_we_i && wb_sel_i[0]) next_st.evt_mask = wval[eid_pkg::EVT_WIDTH-1:0];
			end else if (wb_adr_i == eid_pkg::OFS_VECTOR) begin
				// read-only pending vector
				next_st.ack = 1'b1;
				next_st.rdata = {23'h000000, any_req, req_vector};
			end else begin
				// unmapped address answers with err
				next_st.err = 1'b1;
				next_st.rdata = 32'h00000000;
			end
		end
		// set wins over either clear
		next_flags = (flags & ~(hw_clear | sw_clear)) | hit;
		next_st.int_flag_low = next_flags[7:0];
		next_st.int_flag_high = next_flags[15:8];
		// wake while in standby on nmi or any detected line
		next_st.wake = standby & (nmi_edge | (|hit));
		// sticky events; set wins over write-one clear
		if (nmi_edge) next_st.evt_status[eid_pkg::EVT_NMI_POS] = 1'b1;
		if (next_st.wake) next_st.evt_status[eid_pkg::EVT_WAKE_POS] = 1'b1;
	end

	// single register stage for all state
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			// registers and flags start cleared
			st.int_enable_low <= eid_pkg::ENABLE_RESET;
			st.int_enable_high <= eid_pkg::ENABLE_RESET;
			st.int_flag_low <= eid_pkg::FLAG_RESET;
			st.int_flag_high <= eid_pkg::FLAG_RESET;
			st.sense_select_reg <= eid_pkg::SENSE_RESET;
			st.src_alt <= eid_pkg::SOURCE_RESET;
			st.system_control_reg <= 8'h00;
			st.read_one <= 16'h0000;
			// nmi history idles high like the synchroniser
			st.nmi_prev <= 1'b1;
			st.nmi_pulse <= 1'b0;
			st.wake <= 1'b0;
			st.evt_status <= '0;
			st.evt_mask <= '0;
			// bus answer idle
			st.ack <= 1'b0;
			st.err <= 1'b0;
			st.rdata <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign line_req = flags & enables;
	// any enabled pending line
	assign req_valid = any_req;
	// per-line vector number
	assign req_vector = best[3] ? (eid_pkg::VEC_BASE_HIGH + 8'(best[2:0])) :
		(eid_pkg::VEC_BASE_LOW + 8'(best[2:0]));
	assign nmi_req = st.nmi_pulse;
	// wake from standby; one cycle per edge, held while a low-level line is low
	assign wake = st.wake;
	// bus answer and read data come straight from flops
	assign wb_ack_o = st.ack;
	assign wb_err_o = st.err;
	assign wb_dat_o = st.rdata;
	// level interrupt while an unmasked event is pending
	assign irq = |(st.evt_status & st.evt_mask);
endmodule

// File: eid_top_checker.sv
// eid_top_checker: port assertions for eid_top.
// assumes the bind at the foot; single mclk domain.
`timescale 1ns/1ns
module eid_top_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// pins and requests
	input wire logic nmi_pin,
	input wire logic standby,
	input wire logic [15:0] line_req,
	input wire logic [7:0] req_vector,
	input wire logic req_valid,
	input wire logic nmi_req,
	input wire logic wake
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// vector of lowest pending line
	function automatic logic [7:0] vec_of(input logic [15:0] r);
		vec_of = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			if (r[i]) vec_of = (i < 8) ? eid_pkg::VEC_BASE_LOW + 8'(i) : eid_pkg::VEC_BASE_HIGH + 8'(i - 8);
		end
	endfunction
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no bus answer");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_err;
		!(wb_ack_o && wb_err_o);
	endproperty
	a_ack_err: assert property (p_ack_err) else $error("ack with err");
	property p_rst_req;
		!$past(rstn) |-> line_req == 16'h0000;
	endproperty
	a_rst_req: assert property (p_rst_req) else $error("request after reset");
	property p_valid;
		$stable(line_req) |-> req_valid == (line_req != 16'h0000);
	endproperty
	a_valid: assert property (p_valid) else $error("valid mismatch");
	property p_vec;
		$stable(line_req) && line_req != 16'h0000 |-> req_vector == vec_of(line_req);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector");
	property p_nmi_pulse;
		nmi_req |=> !nmi_req;
	endproperty
	a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse long");
	property p_nmi_src;
		nmi_req |-> $past(nmi_pin, 1) != $past(nmi_pin, 6);
	endproperty
	a_nmi_src: assert property (p_nmi_src) else $error("nmi without edge");
	property p_wake;
		wake |-> $past(standby);
	endproperty
	a_wake: assert property (p_wake) else $error("wake outside standby");
	// main scenarios reached
	c_ack: cover property (wb_ack_o);
	c_err: cover property (wb_err_o);
	c_nmi: cover property (nmi_req);
	c_wake: cover property (wake);
endmodule
bind eid_top eid_top_checker u_chk (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .nmi_pin(nmi_pin), .standby(standby), .line_req(line_req),
	.req_vector(req_vector), .req_valid(req_valid), .nmi_req(nmi_req), .wake(wake));

// File: eid_top_tb.sv
// eid_top_tb: self-checking bench for eid_top.
// assumes eid_pins_model drives the pins and the bench is bus master.
`timescale 1ns/1ns
module eid_top_tb;
	// clock, reset and bus signals
	logic mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, lack = 0, stby = 0;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0, rq;
	logic [3:0] anum = 0;
	logic re;
	// byte lanes of the bus, normally all on
	logic [3:0] sel = 4'hF;
	// pulses seen on nmi_req and wake; wake stays high while a low-level line is low
	int nmi_cnt = 0, wake_cnt = 0;
	int fail_count = 0, comparisons = 0;
	// outputs
	logic [31:0] dat_o;
	logic ack, err, rv, nmi_req, wake, irq, nmi;
	logic [15:0] pin_n, alt_n, req;
	logic [7:0] vec;
	// reset values: address beside expected read
	logic [39:0] rows [6] = '{{eid_pkg::OFS_ENABLE_LOW, 24'h0, eid_pkg::ENABLE_RESET},
		{eid_pkg::OFS_ENABLE_HIGH, 24'h0, eid_pkg::ENABLE_RESET}, {eid_pkg::OFS_FLAG_LOW, 24'h0, eid_pkg::FLAG_RESET},
		{eid_pkg::OFS_FLAG_HIGH, 24'h0, eid_pkg::FLAG_RESET}, {eid_pkg::OFS_SENSE, eid_pkg::SENSE_RESET},
		{eid_pkg::OFS_SOURCE, 16'h0, eid_pkg::SOURCE_RESET}};
	always #10 mclk = ~mclk;
	// count nmi and wake pulses as the design sees its own edge
	always @(posedge mclk) begin
		if (nmi_req === 1'b1) nmi_cnt++;
		if (wake === 1'b1) wake_cnt++;
	end
	eid_pins_model pins (.mclk(mclk), .irq_pin_n(pin_n), .alt_request_pin_n(alt_n), .nmi_pin(nmi));
	eid_top dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .irq_pin_n(pin_n),
		.alt_request_pin_n(alt_n), .nmi_pin(nmi), .line_ack(lack), .line_ack_num(anum), .standby(stby),
		.line_req(req), .req_vector(vec), .req_valid(rv), .nmi_req(nmi_req), .wake(wake), .irq(irq));
	// one classic cycle, held until ack or err is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		// no answer within the limit counts as a mismatch
		if (ack !== 1'b1 && err !== 1'b1) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, ack, 1'b1);
		end
		rq = dat_o;
		re = err;
		{cyc, stb} <= 2'b00;
	endtask
	// compare one value
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// one-cycle handling pulse for a line
	task automatic hdl(input logic [3:0] n);
		@(posedge mclk);
		{lack, anum} <= {1'b1, n};
		@(posedge mclk);
		lack <= 1'b0;
	endtask
	task automatic final_report();
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// watchdog
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			wb(0, rows[i][39:32], 0);
			chk(rq, rows[i][31:0]);
		end
		// lines 0..3 low, fall, rise, both; line 8 from its alternate pin
		wb(1, eid_pkg::OFS_SENSE, 32'h0001_00E4);
		wb(1, eid_pkg::OFS_SOURCE, 32'h0000_0100);
		pins.drive(16'hFEF0, 16'hFFFF, 1, 6);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0B);
		pins.drive(16'hFFFF, 16'hFEFF, 1, 6);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0F);
		wb(0, eid_pkg::OFS_FLAG_HIGH, 0);
		chk(rq, 32'h01);
		wb(1, eid_pkg::OFS_ENABLE_LOW, 32'h04);
		wb(1, eid_pkg::OFS_ENABLE_HIGH, 32'h01);
		chk({16'h0, req}, 32'h0104);
		chk({31'h0, rv}, 1);
		chk({24'h0, vec}, {24'h0, eid_pkg::VEC_BASE_LOW + 8'h02});
		// a write with lane 0 off leaves the enables alone
		sel <= 4'hE;
		wb(1, eid_pkg::OFS_ENABLE_LOW, 32'hFF);
		sel <= 4'hF;
		wb(0, eid_pkg::OFS_ENABLE_LOW, 0);
		chk(rq, 32'h04);
		// zero write without an armed read is ignored
		wb(1, eid_pkg::OFS_FLAG_LOW, 32'hFF);
		wb(1, eid_pkg::OFS_FLAG_LOW, 32'h00);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0F);
		wb(1, eid_pkg::OFS_FLAG_LOW, 32'h0E);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0E);
		hdl(1);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0C);
		// low level: handling while low keeps the flag
		pins.drive(16'hFFFE, 16'hFFFF, 1, 6);
		hdl(0);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0D);
		pins.drive(16'hFFFF, 16'hFFFF, 1, 6);
		hdl(0);
		wb(0, eid_pkg::OFS_FLAG_LOW, 0);
		chk(rq, 32'h0C);
		// nmi on rising edge only; a falling edge is ignored
		wb(1, eid_pkg::OFS_SYSCTL, 32'h1);
		pins.drive(16'hFFFF, 16'hFFFF, 0, 8);
		wb(0, eid_pkg::OFS_EVT_STATUS, 0);
		chk(rq & 32'h3, 0);
		chk(nmi_cnt, 0);
		pins.drive(16'hFFFF, 16'hFFFF, 1, 8);
		chk(nmi_cnt, 1);
		chk({31'h0, irq}, 0);
		wb(1, eid_pkg::OFS_EVT_MASK, 32'h1);
		@(posedge mclk);
		chk({31'h0, irq}, 1);
		wb(1, eid_pkg::OFS_EVT_STATUS, 32'h1);
		@(posedge mclk);
		chk({31'h0, irq}, 0);
		// wake from standby on a line
		stby <= 1'b1;
		pins.drive(16'hFFFB, 16'hFFFF, 1, 6);
		pins.drive(16'hFFFF, 16'hFFFF, 1, 6);
		stby <= 1'b0;
		chk(wake_cnt, 1);
		wb(0, eid_pkg::OFS_EVT_STATUS, 0);
		chk(rq & 32'h3, 32'h2);
		wb(0, 8'hF0, 0);
		chk({31'h0, re}, 1);
		// reset in mid-run drops requests and clears the registers
		@(posedge mclk);
		rstn <= 1'b0;
		@(posedge mclk);
		chk({16'h0, req}, 32'h0);
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		wb(0, eid_pkg::OFS_ENABLE_HIGH, 0);
		chk(rq, 32'h0);
		wb(0, eid_pkg::OFS_FLAG_HIGH, 0);
		chk(rq, 32'h0);
		final_report();
	end
endmodule
